// ---- design/scp_pkg.sv ----
package scp_pkg;
    localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h02;
    localparam logic [7:0] ADDR_CHANNEL_POINTER = 8'h03;
    localparam logic [7:0] ADDR_DATA_BASE = 8'h40;
    localparam logic [7:0] ADDR_DATA_LAST = 8'h7F;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_WRITABLE = 8'hBF;
    localparam int BIT_INDICATOR_DARK = 7;
    localparam int BIT_STIM_HI = 5;
    localparam int BIT_STIM_LO = 3;
    localparam int BIT_SIGNED_FORMAT = 2;
    localparam int BIT_DOUBLE_PAGE = 1;
    localparam int BIT_SCAN_HOLD = 0;
    localparam logic [4:0] PAGE_CHANNELS_M1 = 5'h0F;
    localparam logic [4:0] ALL_CHANNELS_M1 = 5'h1F;
    localparam int CLOCK_MHZ = 100;
    localparam int HOLD_PERIOD_MS = 25;
    localparam int HOLD_PERIOD_CYCLES = HOLD_PERIOD_MS * 1000 * CLOCK_MHZ;
    localparam int SCAN_PERIOD_CYCLES = HOLD_PERIOD_CYCLES;
    localparam int SAMPLE_WIDTH = 12;
    localparam int DATA_WIDTH = 16;
    typedef enum logic [2:0] {
        SCP_STIM_EXTERNAL = 3'b000,
        SCP_STIM_ZERO = 3'b111,
        SCP_STIM_LOW = 3'b101,
        SCP_STIM_MID = 3'b011,
        SCP_STIM_HIGH = 3'b001
    } scp_stim_t;
    typedef enum logic [1:0] {
        SCP_IDLE = 2'b00,
        SCP_CONVERT = 2'b01,
        SCP_STORE = 2'b10
    } scp_state_t;
endpackage

// ---- design/scp_format.sv ----
`timescale 1ns/1ps
`default_nettype none
module scp_format (
    input wire logic [scp_pkg::SAMPLE_WIDTH-1:0] sample,
    input wire logic signed_format,
    output logic [scp_pkg::DATA_WIDTH-1:0] result
);
    import scp_pkg::*;
    wire logic [SAMPLE_WIDTH-1:0] flipped;
    // Offset binary flips its top bit to become two's complement.
    assign flipped = {~sample[SAMPLE_WIDTH-1], sample[SAMPLE_WIDTH-2:0]};
    assign result = signed_format
        ? {{(DATA_WIDTH-SAMPLE_WIDTH){flipped[SAMPLE_WIDTH-1]}}, flipped}
        : {{(DATA_WIDTH-SAMPLE_WIDTH){1'b0}}, sample};
endmodule // scp_format
`default_nettype wire

// ---- design/scp_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module scp_control #(
    parameter int SCAN_CYCLES = scp_pkg::SCAN_PERIOD_CYCLES,
    parameter int HOLD_CYCLES = scp_pkg::HOLD_PERIOD_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic single_ended,
    input wire logic [7:0] bus_addr,
    input wire logic bus_write,
    input wire logic bus_read,
    input wire logic [7:0] bus_wdata,
    input wire logic [15:0] bus_wdata_word,
    output logic [15:0] bus_rdata,
    output logic indicator_on,
    output logic [2:0] stimulus_select,
    output logic [4:0] convert_channel,
    output logic convert_start,
    input wire logic convert_done,
    input wire logic [scp_pkg::SAMPLE_WIDTH-1:0] convert_sample
);
    import scp_pkg::*;

    logic [7:0] control_status_reg;
    logic [4:0] channel_pointer_reg;
    logic [DATA_WIDTH-1:0] data_ram [0:31];
    scp_state_t state;
    logic [31:0] pace;
    logic [2:0] next_stimulus;

    wire logic [4:0] last_index;
    wire logic hold;
    wire logic double_page;
    wire logic wr_control;
    wire logic wr_data;
    wire logic [4:0] wr_index;
    wire logic [4:0] rd_index;
    wire logic [DATA_WIDTH-1:0] formatted;
    wire logic [31:0] period;
    wire logic pace_done;
    wire logic [4:0] next_pointer;
    wire logic [15:0] next_rdata;
    wire logic store_now;

    function automatic logic [4:0] data_index(input logic [7:0] addr);
        data_index = addr[5:1];
    endfunction

    assign hold = control_status_reg[BIT_SCAN_HOLD];
    assign double_page = control_status_reg[BIT_DOUBLE_PAGE] & ~single_ended;
    assign last_index = (single_ended | double_page)
        ? ALL_CHANNELS_M1 : PAGE_CHANNELS_M1;
    assign wr_control = bus_write && bus_addr == ADDR_CONTROL_STATUS;
    assign wr_data = bus_write && bus_addr >= ADDR_DATA_BASE
        && bus_addr <= ADDR_DATA_LAST;
    assign wr_index = data_index(bus_addr);
    assign rd_index = data_index(bus_addr);
    // The sample is only valid in the cycle that carries convert_done.
    assign store_now = state == SCP_CONVERT && convert_done;
    assign period = hold ? HOLD_CYCLES : SCAN_CYCLES;
    assign pace_done = pace >= period - 1;
    assign next_pointer = (channel_pointer_reg >= last_index)
        ? 5'h00 : channel_pointer_reg + 5'h01;
    assign next_stimulus = control_status_reg[BIT_STIM_LO]
        ? control_status_reg[BIT_STIM_HI:BIT_STIM_LO] : SCP_STIM_EXTERNAL;
    assign next_rdata = (bus_addr == ADDR_CONTROL_STATUS)
        ? {control_status_reg, 3'b000, channel_pointer_reg}
        : (bus_addr == ADDR_CHANNEL_POINTER)
        ? {8'h00, 3'b000, channel_pointer_reg}
        : (bus_addr >= ADDR_DATA_BASE && bus_addr <= ADDR_DATA_LAST)
        ? data_ram[rd_index] : 16'h0000;

    scp_format u_format (
        .sample(convert_sample),
        .signed_format(control_status_reg[BIT_SIGNED_FORMAT]),
        .result(formatted)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            control_status_reg <= CONTROL_RESET;
        end else if (wr_control) begin
            control_status_reg <= bus_wdata & CONTROL_WRITABLE;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            indicator_on <= 1'b1;
            stimulus_select <= SCP_STIM_EXTERNAL;
            bus_rdata <= 16'h0000;
        end else begin
            indicator_on <= ~control_status_reg[BIT_INDICATOR_DARK];
            stimulus_select <= next_stimulus;
            bus_rdata <= bus_read ? next_rdata : 16'h0000;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pace <= 32'h0000_0000;
        end else if (pace_done) begin
            pace <= 32'h0000_0000;
        end else begin
            pace <= pace + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= SCP_IDLE;
            channel_pointer_reg <= 5'h00;
            convert_start <= 1'b0;
            convert_channel <= 5'h00;
        end else begin
            convert_start <= 1'b0;
            unique case (state)
                SCP_IDLE: begin
                    if (pace_done) begin
                        convert_start <= 1'b1;
                        convert_channel <= double_page
                            ? {1'b0, channel_pointer_reg[3:0]}
                            : channel_pointer_reg;
                        state <= SCP_CONVERT;
                    end
                end
                SCP_CONVERT: begin
                    if (convert_done) begin
                        state <= SCP_STORE;
                    end
                end
                SCP_STORE: begin
                    if (!hold) begin
                        channel_pointer_reg <= next_pointer;
                    end
                    state <= SCP_IDLE;
                end
                default: state <= SCP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (store_now) begin
            data_ram[channel_pointer_reg] <= formatted;
        end else if (wr_data) begin
            data_ram[wr_index] <= bus_wdata_word;
        end
    end

    property p_pointer_range;
        @(posedge clock) disable iff (rst)
        state == SCP_STORE && !hold && channel_pointer_reg >= last_index
            |=> channel_pointer_reg == 5'h00;
    endproperty
    a_pointer_range: assert property (p_pointer_range)
        else $error("pointer did not wrap");

    property p_hold_stays;
        @(posedge clock) disable iff (rst)
        hold && $past(hold) |-> $stable(channel_pointer_reg);
    endproperty
    a_hold_stays: assert property (p_hold_stays)
        else $error("pointer moved while held");

    property p_indicator;
        @(posedge clock) disable iff (rst)
        wr_control |=> ##1 indicator_on == ~$past(bus_wdata[7], 2);
    endproperty
    a_indicator: assert property (p_indicator)
        else $error("indicator mismatch");

    property p_reserved;
        @(posedge clock) disable iff (rst)
        wr_control |=> control_status_reg[6] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit set");

    property p_resume;
        @(posedge clock) disable iff (rst)
        state == SCP_STORE && !hold && channel_pointer_reg < last_index
            |=> channel_pointer_reg == $past(channel_pointer_reg) + 5'h01;
    endproperty
    a_resume: assert property (p_resume)
        else $error("pointer did not advance by one");

    property p_stimulus;
        @(posedge clock) disable iff (rst)
        !control_status_reg[BIT_STIM_LO]
            |=> stimulus_select == SCP_STIM_EXTERNAL;
    endproperty
    a_stimulus: assert property (p_stimulus)
        else $error("stimulus not external");

    property p_sixteen;
        @(posedge clock) disable iff (rst)
        !single_ended && !control_status_reg[BIT_DOUBLE_PAGE]
            |-> last_index == PAGE_CHANNELS_M1;
    endproperty
    a_sixteen: assert property (p_sixteen)
        else $error("wrong active count");

    sequence s_start;
        convert_start;
    endsequence
    property p_start;
        @(posedge clock) disable iff (rst)
        s_start |-> state == SCP_CONVERT;
    endproperty
    a_start: assert property (p_start)
        else $error("start without conversion");

    sequence s_result;
        state == SCP_CONVERT && convert_done;
    endsequence
    property p_store;
        @(posedge clock) disable iff (rst)
        s_result |=> state == SCP_STORE;
    endproperty
    a_store: assert property (p_store)
        else $error("result not stored");

    property p_read_pointer;
        @(posedge clock) disable iff (rst)
        bus_read && bus_addr == ADDR_CHANNEL_POINTER
            |=> bus_rdata == {11'h000, $past(channel_pointer_reg)};
    endproperty
    a_read_pointer: assert property (p_read_pointer)
        else $error("pointer read mismatch");

    property p_read_reserved;
        @(posedge clock) disable iff (rst)
        bus_read && bus_addr > ADDR_CHANNEL_POINTER
            && bus_addr < ADDR_DATA_BASE
            |=> bus_rdata == 16'h0000;
    endproperty
    a_read_reserved: assert property (p_read_reserved)
        else $error("reserved read not zero");

    property p_stim_code;
        @(posedge clock) disable iff (rst)
        control_status_reg[BIT_STIM_LO]
            |=> stimulus_select
                == $past(control_status_reg[BIT_STIM_HI:BIT_STIM_LO]);
    endproperty
    a_stim_code: assert property (p_stim_code)
        else $error("stimulus code mismatch");

    property p_channel;
        @(posedge clock) disable iff (rst)
        convert_start |-> convert_channel[3:0] == channel_pointer_reg[3:0];
    endproperty
    a_channel: assert property (p_channel)
        else $error("channel does not follow pointer");

    property p_single_range;
        @(posedge clock) disable iff (rst)
        single_ended |-> last_index == ALL_CHANNELS_M1;
    endproperty
    a_single_range: assert property (p_single_range)
        else $error("single-ended range wrong");
endmodule // scp_control
`default_nettype wire

// ---- test/scp_conv_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module scp_conv_model #(
    parameter int LATENCY = 3
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic convert_start,
    input wire logic [4:0] convert_channel,
    output logic convert_done,
    output logic [scp_pkg::SAMPLE_WIDTH-1:0] convert_sample
);
    int count;
    logic [4:0] channel;
    // The sample lines toggle between results, so no stale value survives.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count <= 0;
            channel <= 5'h00;
            convert_done <= 1'b0;
            convert_sample <= 12'h0A5;
        end else begin
            convert_done <= (count == 1);
            if (count == 1) begin
                convert_sample <= {channel[0], 6'h00, channel};
            end else begin
                convert_sample <= ~convert_sample;
            end
            if (convert_start) begin
                count <= LATENCY;
                channel <= convert_channel;
            end else if (count > 0) begin
                count <= count - 1;
            end
        end
    end
endmodule // scp_conv_model
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
    import scp_pkg::*;
    logic clock = 0, rst = 1, single_ended = 0, bus_write = 0, bus_read = 0;
    logic [7:0] bus_addr = 0, bus_wdata = 0, mx;
    logic [15:0] bus_wdata_word = 0, bus_rdata, d;
    logic indicator_on, convert_start, convert_done;
    logic [2:0] stimulus_select;
    logic [2:0] codes [5] = '{3'b000, 3'b111, 3'b101, 3'b011, 3'b001};
    logic [4:0] convert_channel, ch, p;
    logic [11:0] convert_sample;
    int errors = 0, samples_checked = 0;
    scp_control #(.SCAN_CYCLES(4), .HOLD_CYCLES(4)) i_dut (.clock(clock),
        .rst(rst), .single_ended(single_ended), .bus_addr(bus_addr),
        .bus_write(bus_write), .bus_read(bus_read), .bus_wdata(bus_wdata),
        .bus_wdata_word(bus_wdata_word), .bus_rdata(bus_rdata),
        .indicator_on(indicator_on), .stimulus_select(stimulus_select),
        .convert_channel(convert_channel), .convert_start(convert_start),
        .convert_done(convert_done), .convert_sample(convert_sample));
    scp_conv_model i_conv (.clock(clock), .rst(rst),
        .convert_start(convert_start), .convert_channel(convert_channel),
        .convert_done(convert_done), .convert_sample(convert_sample));
    initial forever #5 clock = ~clock;
    task automatic end_sim();
        if (errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clock);
        #1 {bus_addr, bus_wdata, bus_wdata_word, bus_write} = {a, v[7:0], v, 1'b1};
        @(posedge clock);
        #1 bus_write = 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clock);
        #1 {bus_addr, bus_read} = {a, 1'b1};
        @(posedge clock);
        #1 bus_read = 0;
        v = bus_rdata;
    endtask
    task automatic next_start(output logic [4:0] c);
        int n;
        n = 0;
        do begin @(negedge clock); n++; end
        while (convert_start !== 1'b1 && n < 200);
        `CHK(convert_start, 1'b1)
        c = convert_channel;
    endtask
    task automatic scan_seq(input int n, input int m);
        logic [4:0] a, b;
        // A range change may leave one start from the old pointer range.
        next_start(a);
        next_start(a);
        repeat (n) begin
            next_start(b);
            `CHK(b, 5'((a + 1) % m))
            a = b;
        end
    endtask
    function automatic logic [15:0] expv(input logic [4:0] c, input logic s);
        logic [11:0] v;
        v = {c[0], 6'h00, c};
        return s ? {{5{~v[11]}}, v[10:0]} : {4'h0, v};
    endfunction
    initial begin
        repeat (6) @(posedge clock);
        #1 rst = 0;
        rd(ADDR_CONTROL_STATUS, d);
        `CHK(d[15:8], CONTROL_RESET)
        `CHK(indicator_on, 1'b1)
        wr(8'h02, 16'h00FF);
        rd(8'h02, d);
        `CHK(d[15:8], 8'hBF)
        `CHK(indicator_on, 1'b0)
        foreach (codes[i]) begin
            wr(8'h02, {10'h000, codes[i], 3'b000});
            rd(8'h03, d);
            `CHK(stimulus_select, codes[i])
            `CHK(d[15:5], 11'h000)
        end
        wr(8'h03, 16'h001F);
        wr(8'h10, 16'hFFFF);
        rd(8'h10, d);
        `CHK(d, 16'h0000)
        rd(8'h02, d);
        `CHK(d[15:8], 8'h08)
        wr(8'h02, 16'h0000);
        wr(8'h66, 16'h5A5A);
        scan_seq(20, 16);
        rd(8'h46, d);
        `CHK(d, expv(5'd3, 1'b0))
        rd(8'h66, d);
        `CHK(d, 16'h5A5A)
        wr(8'h02, 16'h0004);
        scan_seq(17, 16);
        rd(8'h44, d);
        `CHK(d, expv(5'd2, 1'b1))
        rd(8'h46, d);
        `CHK(d, expv(5'd3, 1'b1))
        wr(8'h02, 16'h0002);
        scan_seq(34, 16);
        rd(8'h66, d);
        `CHK(d, expv(5'd3, 1'b0))
        mx = 0;
        repeat (200) begin
            rd(8'h03, d);
            if (d[7:0] > mx) mx = d[7:0];
        end
        `CHK(mx, 8'h1F)
        wr(8'h02, 16'h0000);
        scan_seq(20, 16);
        // Hold is set while the pointer sits on a channel.
        wr(8'h02, 16'h0001);
        rd(8'h03, d);
        p = d[4:0];
        rd({3'b010, p[3:0] - 4'd1, 1'b0}, d);
        `CHK(d, expv({1'b0, p[3:0] - 4'd1}, 1'b0))
        wr({3'b010, p[3:0] + 4'd3, 1'b0}, 16'hABCD);
        repeat (100) @(posedge clock);
        next_start(ch);
        `CHK(ch, p)
        rd({3'b010, p[3:0] + 4'd3, 1'b0}, d);
        `CHK(d, 16'hABCD)
        wr(8'h02, 16'h0000);
        next_start(ch);
        `CHK(ch === p || ch[3:0] === p[3:0] + 4'd1, 1'b1)
        @(posedge clock);
        #1 {rst, single_ended} = 2'b11;
        repeat (2) @(posedge clock);
        #1 rst = 0;
        rd(8'h02, d);
        `CHK(d[15:8], 8'h00)
        scan_seq(40, 32);
        rd(8'h68, d);
        `CHK(d, expv(5'd20, 1'b0))
        end_sim();
    end
    initial begin
        #300000;
        errors++;
        end_sim();
    end
endmodule // testbench
`default_nettype wire
